// ---- rft_timer_control.sv ----
// general purpose and no-response timer control with apb registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module rft_timer_control
  import rft_pkg::*;
#(
  parameter int unsigned CLK_HZ     = 25000000,
  parameter int unsigned CARRIER_HZ = 13560000
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // commands and frame events, one-cycle pulses
  input  wire logic              startGpCmd,
  input  wire logic              startNrCmd,
  input  wire logic              rxEnd,
  input  wire logic              rxStart,
  input  wire logic              txEnd,
  input  wire logic              peerFieldOn,
  input  wire logic              responseSeen,
  // mode and no-response timeout from outside
  input  wire logic              active_peer_mode,
  input  wire logic [TMR_W-1:0]  nrTimeout,
  // results
  output logic                   irq,
  output logic                   fieldOffReq,
  output logic                   maskRxTick,
  output logic                   nrPayMode
);

  // refuse rates the accumulator cannot serve
  if (CARRIER_HZ == 0 || CLK_HZ == 0 || CARRIER_HZ > 8 * CLK_HZ) begin : g_bad_rate
    $error("rft_timer_control: unusable clock or carrier rate");
  end

  // register state
  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] gpHigh_q;
  logic [REG_W-1:0] gpLow_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] mask_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic             irq_q;
  logic             fieldOff_q;

  // bus decode
  logic              setupPh;
  logic              wrEn;
  logic [5:0]        regIdx;
  logic              addrHit;
  logic [DATA_W-1:0] rdValue;

  // control decode
  rft_trig_t         trig;
  logic              extraStart;
  logic              gpStart;
  logic              peerTxMode;
  logic              nrAuto;
  logic              nrStart;
  logic              nrStop;
  logic [STEP_W-1:0] nrStep;
  logic [STEP_W-1:0] mrStep;

  // counter bundles
  rft_tick_if gpBus ();
  rft_tick_if nrBus ();

  // apb front end

  assign setupPh = psel && !penable;
  assign wrEn    = psel && penable && pready_q && pwrite;
  assign regIdx  = paddr[7:2];

  // address decode and read mux
  always_comb begin
    addrHit = 1'b1;
    rdValue = '0;
    case (regIdx)
      IDX_MODE_CTRL:  rdValue[REG_W-1:0] = ctrl_q;
      IDX_GP_HIGH:    rdValue[REG_W-1:0] = gpHigh_q;
      IDX_GP_LOW:     rdValue[REG_W-1:0] = gpLow_q;
      IDX_IRQ_STATUS: begin
        rdValue[IRQ_W-1:0] = stat_q;
        rdValue[GP_RUN_BIT] = gpBus.running;
        rdValue[NR_RUN_BIT] = nrBus.running;
      end
      IDX_IRQ_MASK:   rdValue[IRQ_W-1:0] = mask_q;
      IDX_GP_COUNT:   rdValue[TMR_W-1:0] = gpBus.count;
      IDX_NR_COUNT:   rdValue[TMR_W-1:0] = nrBus.count;
      default:        addrHit = 1'b0;
    endcase
  end

  // answer in the first access cycle: ready follows setup by one edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setupPh;
    end
  end

  // error flag for unmapped addresses, raised with ready
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setupPh && !addrHit;
    end
  end

  // read data captured at setup, held through the access cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= '0;
    end else if (setupPh) begin
      prdata_q <= pwrite ? '0 : rdValue;
    end
  end

  // software registers

  // timer control, reserved bit 4 stays zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= MODE_CTRL_RST;
    end else if (wrEn && regIdx == IDX_MODE_CTRL) begin
      ctrl_q <= pwdata[REG_W-1:0] & MODE_CTRL_WM;
    end
  end

  // timeout byte split
  // upper timeout byte in the first timer register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpHigh_q <= GP_BYTE_RST;
    end else if (wrEn && regIdx == IDX_GP_HIGH) begin
      gpHigh_q <= pwdata[REG_W-1:0];
    end
  end

  // lower timeout byte in the second timer register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpLow_q <= GP_BYTE_RST;
    end else if (wrEn && regIdx == IDX_GP_LOW) begin
      gpLow_q <= pwdata[REG_W-1:0];
    end
  end

  // interrupt mask, a one suppresses the matching source
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= '0;
    end else if (wrEn && regIdx == IDX_IRQ_MASK) begin
      mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // trigger selection

  assign trig = rft_trig_t'(ctrl_q[TRIG_MSB:TRIG_LSB]);

  // trigger field decode
  // extra start source chosen by the trigger code
  always_comb begin
    case (trig)
      TRIG_CMD_ONLY: extraStart = 1'b0;
      TRIG_RX_END:   extraStart = rxEnd;
      TRIG_RX_START: extraStart = rxStart;
      TRIG_TX_END:   extraStart = txEnd;
      default:       extraStart = 1'b0;
    endcase
  end

  assign gpStart = startGpCmd || extraStart;

  // peer mode with the end-of-transmit trigger selected
  assign peerTxMode = active_peer_mode && (trig == TRIG_TX_END);

  // no-response start and stop

  always_comb begin
    if (!active_peer_mode) begin
      nrAuto = txEnd;
    end else if (peerTxMode) begin
      nrAuto = ctrl_q[NRT_PEER_BIT] ? peerFieldOn : txEnd;
    end else begin
      nrAuto = 1'b0;
    end
  end

  // a zero timeout leaves the no-response timer stopped
  assign nrStart = (startNrCmd || nrAuto) && (nrTimeout != '0);

  // compliance mode keeps timing
  // a response stops the timer only in the ordinary mode
  assign nrStop = responseSeen && !ctrl_q[NRT_PAY_BIT];

  // step sizes

  assign nrStep = ctrl_q[NRT_STEP_BIT] ? STEP_NRT_LG : STEP_SHORT;
  assign mrStep = ctrl_q[MRT_STEP_BIT] ? STEP_MRT_LG : STEP_SHORT;

  // eight carrier periods
  // step ticks of the general purpose timer, phase restarted by a start
  rft_prescaler #(
    .CLK_HZ     (CLK_HZ),
    .CARRIER_HZ (CARRIER_HZ)
  ) u_gp_pre (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (gpStart),
    .periods (STEP_GP),
    .tick    (gpBus.tick)
  );

  // step ticks of the no-response timer
  rft_prescaler #(
    .CLK_HZ     (CLK_HZ),
    .CARRIER_HZ (CARRIER_HZ)
  ) u_nr_pre (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (nrStart),
    .periods (nrStep),
    .tick    (nrBus.tick)
  );

  // mask receive step pulses, phase aligned to end of transmit
  rft_prescaler #(
    .CLK_HZ     (CLK_HZ),
    .CARRIER_HZ (CARRIER_HZ)
  ) u_mr_pre (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (txEnd),
    .periods (mrStep),
    .tick    (maskRxTick)
  );

  // counters

  assign gpBus.start = gpStart;
  assign gpBus.stop  = 1'b0;
  assign gpBus.load  = {gpHigh_q, gpLow_q};

  assign nrBus.start = nrStart;
  assign nrBus.stop  = nrStop;
  assign nrBus.load  = nrTimeout;

  rft_down_counter u_gp_cnt (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (gpBus.cnt)
  );

  rft_down_counter u_nr_cnt (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (nrBus.cnt)
  );

  // interrupts

  // sticky status, a hardware set wins over a same-cycle clear
  always_comb begin
    stat_d = stat_q;
    if (wrEn && regIdx == IDX_IRQ_STATUS) begin
      stat_d = stat_q & ~pwdata[IRQ_W-1:0];
    end
    if (gpBus.expire) begin
      stat_d[IRQ_GP_BIT] = 1'b1;
    end
    if (nrBus.expire) begin
      stat_d[IRQ_NRT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // mask gates the line
  // level interrupt from unmasked status bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & ~mask_q);
    end
  end

  // field control

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fieldOff_q <= 1'b0;
    end else begin
      fieldOff_q <= gpBus.expire && peerTxMode;
    end
  end

  // outputs
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign fieldOffReq = fieldOff_q;
  assign nrPayMode   = ctrl_q[NRT_PAY_BIT];

endmodule

// ---- rft_pkg.sv ----
// constants, register map and encodings of the rf timer control block
// Contract
// - timer control bits 7..5 choose the general purpose timer's extra start trigger
// - the start-general-purpose-timer command always starts the timer
// - trigger code 000 starts the timer from the command alone
// - trigger code 001 also starts the timer at end of reception
// - trigger code 010 also starts the timer at start of reception
// - trigger code 011 also starts the timer at end of transmission
// - peer mode with code 011: timer expiry switches own field off
// - peer mode with code 011: no-response start follows the peer start bit
// - bit 3 sets mask receive step: 64 or 512 carrier periods
// - peer mode bit 2: no-response starts at end of transmit or peer field on
// - bit 1 puts the no-response timer in payment compliance mode
// - bit 0 sets no-response step: 64 or 4096 carrier periods
// - the 16-bit timeout: upper byte first register, lower byte second
// - timeout counts in steps of eight carrier periods
// - timer expiry raises a maskable general purpose interrupt
// - no-response timeout without a response raises a no-response interrupt
package rft_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned STEP_W = 13;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE_CTRL  = 6'h12;
  localparam logic [5:0] IDX_GP_HIGH    = 6'h13;
  localparam logic [5:0] IDX_GP_LOW     = 6'h14;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h1a;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h1b;
  localparam logic [5:0] IDX_GP_COUNT   = 6'h1c;
  localparam logic [5:0] IDX_NR_COUNT   = 6'h1d;

  // timer control fields
  localparam int unsigned TRIG_MSB      = 7;
  localparam int unsigned TRIG_LSB      = 5;
  localparam int unsigned MRT_STEP_BIT  = 3;
  localparam int unsigned NRT_PEER_BIT  = 2;
  localparam int unsigned NRT_PAY_BIT   = 1;
  localparam int unsigned NRT_STEP_BIT  = 0;
  localparam logic [7:0]  MODE_CTRL_RST = 8'h00;
  localparam logic [7:0]  MODE_CTRL_WM  = 8'hef;
  localparam logic [7:0]  GP_BYTE_RST   = 8'h00;

  // step sizes in carrier periods
  localparam logic [STEP_W-1:0] STEP_GP     = 13'h0008;
  localparam logic [STEP_W-1:0] STEP_SHORT  = 13'h0040;
  localparam logic [STEP_W-1:0] STEP_MRT_LG = 13'h0200;
  localparam logic [STEP_W-1:0] STEP_NRT_LG = 13'h1000;

  // interrupt status layout
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_GP_BIT  = 0;
  localparam int unsigned IRQ_NRT_BIT = 1;
  localparam int unsigned GP_RUN_BIT  = 2;
  localparam int unsigned NR_RUN_BIT  = 3;

  typedef enum logic [2:0] {
    TRIG_CMD_ONLY = 3'h0,
    TRIG_RX_END   = 3'h1,
    TRIG_RX_START = 3'h2,
    TRIG_TX_END   = 3'h3
  } rft_trig_t;

endpackage

// ---- rft_tick_if.sv ----
// bundle between the timer control and one down counter
`timescale 1ns/1ns
interface rft_tick_if;
  import rft_pkg::*;
  logic             start;
  logic             stop;
  logic [TMR_W-1:0] load;
  logic             tick;
  logic             expire;
  logic             running;
  logic [TMR_W-1:0] count;
  modport ctrl (output start, stop, load, tick, input expire, running, count);
  modport cnt  (input start, stop, load, tick, output expire, running, count);
endinterface

// ---- rft_prescaler.sv ----
// fractional step tick generator from the carrier rate
`timescale 1ns/1ns
module rft_prescaler
  import rft_pkg::*;
#(
  parameter int unsigned CLK_HZ     = 25000000,
  parameter int unsigned CARRIER_HZ = 13560000,
  parameter int unsigned ACC_W      = 40
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // control
  input  wire logic              clear,
  input  wire logic [STEP_W-1:0] periods,
  // step pulse
  output logic                   tick
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] limit;
  logic [ACC_W-1:0] sum;

  // refuse an accumulator too narrow for the longest step, or a dead carrier
  if (ACC_W > 62 || CARRIER_HZ == 0 ||
      (64'd1 << ACC_W) <= (64'd1 << STEP_W) * 64'(CLK_HZ)) begin : g_bad_acc
    $error("rft_prescaler: accumulator too narrow");
  end

  // one step lasts periods carrier cycles, measured in clk units
  assign limit = ACC_W'(periods) * ACC_W'(CLK_HZ);
  assign sum   = acc_q + ACC_W'(CARRIER_HZ);

  // accumulate carrier phase, pulse when a step is complete
  always_ff @(posedge clk) begin
    if (!reset_n || clear) begin
      acc_q <= '0;
      tick  <= 1'b0;
    end else if (sum >= limit) begin
      acc_q <= sum - limit;
      tick  <= 1'b1;
    end else begin
      acc_q <= sum;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- rft_down_counter.sv ----
// reloadable step down counter with expiry pulse
`timescale 1ns/1ns
module rft_down_counter
  import rft_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control and result
  rft_tick_if.cnt  port
);
  logic [TMR_W-1:0] count_q;
  logic             run_q;
  logic             exp_q;

  // start reloads, ticks count down, last tick expires
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= '0;
      run_q   <= 1'b0;
      exp_q   <= 1'b0;
    end else if (port.start) begin
      count_q <= port.load;
      run_q   <= 1'b1;
      exp_q   <= 1'b0;
    end else if (port.stop) begin
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (run_q && port.tick) begin
      count_q <= (count_q > TMR_W'(1)) ? count_q - TMR_W'(1) : '0;
      run_q   <= count_q > TMR_W'(1);
      exp_q   <= count_q <= TMR_W'(1);
    end else begin
      exp_q <= 1'b0;
    end
  end

  assign port.expire  = exp_q;
  assign port.running = run_q;
  assign port.count   = count_q;
endmodule

// ---- rft_timer_control_props.sv ----
// port assertions for the rf timer control block
`timescale 1ns/1ns
module rft_timer_control_props
  import rft_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // apb slave side
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // mode and results
  input wire logic              active_peer_mode,
  input wire logic              irq,
  input wire logic              fieldOffReq,
  input wire logic              maskRxTick,
  input wire logic              nrPayMode
);
  logic ctrlWr;

  // control register write in its access cycle
  assign ctrlWr = psel && penable && pready && pwrite && paddr[7:2] == IDX_MODE_CTRL;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // bus phases seen at the ports
  sequence setupS;
    psel && !penable;
  endsequence
  sequence ctrlWrS;
    ctrlWr;
  endsequence
  sequence ctrlRdS;
    pready && !pwrite && paddr[7:2] == IDX_MODE_CTRL;
  endsequence

  AST_SETUP_ANSWER: assert property (setupS |=> pready && penable)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ALIGN: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_SPARE_BIT: assert property (ctrlRdS |-> prdata[4] == 1'b0)
    else $error("spare control bit reads one");
  AST_PAY_FOLLOW: assert property (ctrlWrS |=> nrPayMode == $past(pwdata[NRT_PAY_BIT]))
    else $error("compliance output not from control write");
  AST_PAY_HOLD: assert property (!ctrlWr |=> $stable(nrPayMode))
    else $error("compliance output moved without write");
  AST_FIELD_PEER: assert property (fieldOffReq |-> active_peer_mode)
    else $error("field off request outside peer mode");
  AST_FIELD_PULSE: assert property (fieldOffReq |=> !fieldOffReq)
    else $error("field off request too long");
  AST_TICK_GAP: assert property (maskRxTick |=> !maskRxTick [*8])
    else $error("mask receive ticks too close");
endmodule

// ---- rft_timer_control_tb.sv ----
// self-checking testbench of the rf timer control block
`timescale 1ns/1ns
module rft_timer_control_tb;
  import rft_pkg::*;
  localparam int unsigned CLKF = 25000000;
  localparam int unsigned CARF = 13560000;
  localparam logic [7:0]  A_CTL = 8'h48, A_HI = 8'h4c, A_LO = 8'h50;
  localparam logic [7:0]  A_ST = 8'h68, A_MSK = 8'h6c;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic              startGpCmd, startNrCmd, rxEnd, rxStart, txEnd, peerFieldOn;
  logic              responseSeen, active_peer_mode, irq, fieldOffReq, maskRxTick, nrPayMode;
  logic [APB_AW-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [TMR_W-1:0]  nrTimeout;
  int                err_count, compares, foCount;
  int                gpEv [4] = '{3, 4, 0, 5};

  rft_timer_control #(
    .CLK_HZ     (CLKF),
    .CARRIER_HZ (CARF)
  ) i_dut (
    .clk              (clk),
    .reset_n          (reset_n),
    .paddr            (paddr),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .startGpCmd       (startGpCmd),
    .startNrCmd       (startNrCmd),
    .rxEnd            (rxEnd),
    .rxStart          (rxStart),
    .txEnd            (txEnd),
    .peerFieldOn      (peerFieldOn),
    .responseSeen     (responseSeen),
    .active_peer_mode (active_peer_mode),
    .nrTimeout        (nrTimeout),
    .irq              (irq),
    .fieldOffReq      (fieldOffReq),
    .maskRxTick       (maskRxTick),
    .nrPayMode        (nrPayMode)
  );

  // clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // counts field off pulses
  always @(posedge clk) begin
    if (fieldOffReq === 1'b1) foCount++;
  end

  task conclude;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin err_count++; conclude; end
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1, a, d, r, e);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r; logic e;
    apb(0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  // one-cycle pulse on a command or frame event
  task pulse(input int s);
    @(posedge clk);
    case (s)
      0: txEnd <= 1; 1: peerFieldOn <= 1; 2: startNrCmd <= 1; 3: rxEnd <= 1;
      4: rxStart <= 1; 5: startGpCmd <= 1; default: responseSeen <= 1;
    endcase
    @(posedge clk);
    {txEnd, peerFieldOn, startNrCmd, rxEnd, rxStart, startGpCmd, responseSeen} <= 7'h00;
  endtask

  task waitIrq(input int lim, output logic got, output int n);
    got = 0; n = 0;
    while (!got && n < lim) begin @(posedge clk); n++; got = (irq === 1'b1); end
  endtask

  task t_regs;
    logic [31:0] r; logic e;
    rdchk(A_CTL, 0);
    rdchk(A_HI, 0);
    wr(A_CTL, 32'hff); rdchk(A_CTL, 32'hef);
    chk({31'h0, nrPayMode}, 1);
    wr(A_HI, 32'h123456a5); wr(A_LO, 32'hc3); rdchk(A_HI, 32'ha5);
    rdchk(A_LO, 32'hc3);
    apb(0, 8'h00, 0, r, e); chk(r, 0); chk({31'h0, e}, 1);
    apb(1, 8'h7c, 32'hff, r, e); chk({31'h0, e}, 1);
    wr(A_CTL, 0); wr(A_HI, 0); wr(A_LO, 4);
    chk({31'h0, nrPayMode}, 0);
    $display("test regs done");
  endtask

  task t_gp;
    logic got; int n;
    pulse(5); repeat (30) @(posedge clk); pulse(5); waitIrq(120, got, n);
    chk({31'h0, got}, 1); chk({31'h0, n inside {[58:70]}}, 1);
    rdchk(A_ST, 1); wr(A_ST, 1); repeat (2) @(posedge clk);
    chk({31'h0, irq}, 0); rdchk(A_ST, 0);
    wr(A_MSK, 1); pulse(5); waitIrq(120, got, n); chk({31'h0, got}, 0);
    rdchk(A_ST, 1); wr(A_ST, 1); wr(A_MSK, 0);
    $display("test gp done");
  endtask

  // every trigger code against every start source
  task t_trig;
    logic got; int n;
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 4; v++) begin
        wr(A_CTL, c << 5); pulse(gpEv[v]); waitIrq(100, got, n);
        chk({31'h0, got}, {31'h0, v == 3 || c == v + 1});
        wr(A_ST, 3); repeat (2) @(posedge clk);
      end
    end
    $display("test trig done");
  endtask

  task nrc(input logic [7:0] c, input logic m, input int s, input logic r, input logic x);
    logic got; int n, f;
    active_peer_mode <= m;
    wr(A_CTL, c); f = foCount;
    pulse(s); if (r) pulse(6);
    waitIrq(400, got, n); chk({31'h0, got}, {31'h0, x});
    chk(foCount - f, {31'h0, m && c[7:5] == 3'h3 && s == 0});
    wr(A_ST, 3); repeat (2) @(posedge clk);
  endtask

  task t_nr;
    nrTimeout <= 16'h0002; wr(A_MSK, 1);
    nrc(8'h00, 0, 0, 0, 1); nrc(8'h00, 0, 0, 1, 0); nrc(8'h02, 0, 0, 1, 1);
    nrc(8'h60, 1, 0, 0, 1); nrc(8'h64, 1, 0, 0, 0); nrc(8'h64, 1, 1, 0, 1);
    nrc(8'h20, 1, 0, 0, 0); nrc(8'h20, 1, 2, 0, 1);
    active_peer_mode <= 0; wr(A_MSK, 0);
    $display("test nr done");
  endtask

  task gap(input logic [7:0] c, input int p);
    int n, e;
    e = int'(longint'(p) * CLKF / CARF);
    wr(A_CTL, c);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin @(posedge clk); n++; end while (maskRxTick !== 1'b1 && n < 2000);
    end
    chk({31'h0, n inside {[e-2:e+2]}}, 1);
  endtask

  // long no-response step: one step of 4096 carrier periods
  task t_nrstep;
    logic got; int n, e;
    e = int'(longint'(4096) * CLKF / CARF);
    nrTimeout <= 16'h0001; wr(A_CTL, 8'h01);
    pulse(0); waitIrq(9000, got, n);
    chk({31'h0, got}, 1);
    chk({31'h0, n inside {[e:e+10]}}, 1);
    wr(A_ST, 3); wr(A_CTL, 0);
    $display("test nr step done");
  endtask

  // main sequence
  initial begin
    {reset_n, psel, penable, pwrite, startGpCmd, startNrCmd, rxEnd, rxStart} = 8'h00;
    {txEnd, peerFieldOn, responseSeen, active_peer_mode} = 4'h0;
    paddr = 0; pwdata = 0; nrTimeout = 0;
    err_count = 0; compares = 0; foCount = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1;
    t_regs; t_gp; t_trig; t_nr; t_nrstep;
    gap(8'h00, 64); gap(8'h08, 512);
    $display("test tick done");
    conclude;
  end
endmodule

bind rft_timer_control rft_timer_control_props i_props (
  .clk              (clk),
  .reset_n          (reset_n),
  .paddr            (paddr),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .pwdata           (pwdata),
  .prdata           (prdata),
  .pready           (pready),
  .pslverr          (pslverr),
  .active_peer_mode (active_peer_mode),
  .irq              (irq),
  .fieldOffReq      (fieldOffReq),
  .maskRxTick       (maskRxTick),
  .nrPayMode        (nrPayMode)
);
